// file: verilog/crcu_top.sv
// crc calculation unit: apb register file, data port and interrupt
//
// Function
// - control bit 4 is busy: set by a data write, cleared when done
// - no new data accepted while busy; software waits for zero
// - output reversal bit 3 reverses result bit order when set
// - input reversal bits 2:1: none, per byte, per halfword, word
// - control bit 0 is module reset, set by software, self-clearing
// - polynomial select: 04c11db7, 1021, 07; code 3 also selects 04c11db7
// - seed is 32 bits, resets to all ones, low bits for narrow crc
// - result readable as soon as busy returns to zero
// - module reset restores engine, internal pulse one clock long
// - word takes four cycles, halfword two, byte one
// - each accepted data write folds item into held crc; read gives result
// - before any data, reading the data port returns the seed masked to the crc width
`timescale 1ns/100ps
module crcu_top
    import crcu_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt
    output logic crcIrq
);

    crcu_regs_type st;
    crcu_regs_type next_st;
    crcu_link_if link ();

    logic setupPh;
    logic accessPh;
    logic dataWr;
    logic accepted;
    logic dropped;
    logic calcDone;
    logic [1:0] sizeUnit;
    logic [1:0] inUnit;
    logic [31:0] sizeMask;
    logic [31:0] readValue;
    logic [31:0] readMux;
    logic mapped;

    function automatic logic [31:0] mergeLanes(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] strb);
        for (int b = 0; b < 4; b++) begin
            mergeLanes[b*8 +: 8] = strb[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction

    crcu_engine u_engine (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .link(link)
    );

    ////////////////////////////////////////////////////////////////////
    // data port path
    always_comb begin
        setupPh = psel && !penable;
        accessPh = psel && penable && st.pready;
        dataWr = accessPh && pwrite && (paddr == OFF_DATA);
        // a refused write leaves no trace but a status bit
        accepted = dataWr && !link.busy && st.gate && !st.modRst;
        dropped = dataWr && !accepted;
        calcDone = st.busyPrev && !link.busy;
        // transfer size from byte strobes, items are right aligned
        if (|pstrb[3:2]) begin
            sizeUnit = UNIT_WORD;
            sizeMask = 32'hffffffff;
        end else if (pstrb[1]) begin
            sizeUnit = UNIT_HALF;
            sizeMask = 32'h0000ffff;
        end else begin
            sizeUnit = UNIT_BYTE;
            sizeMask = 32'h000000ff;
        end
        // reversal never spans more than the item itself
        inUnit = (st.inRev < sizeUnit) ? st.inRev : sizeUnit;
    end

    assign link.start = accepted;
    assign link.data = revUnits(pwdata & sizeMask, inUnit);
    assign link.nBytes = (sizeUnit == UNIT_WORD) ? N_WORD :
                         (sizeUnit == UNIT_HALF) ? N_HALF : N_BYTE;
    assign link.polySel = st.polySel;
    assign link.seed = st.seed;
    assign link.reload = st.modRst;
    assign link.enable = st.gate;

    // result as software sees it
    always_comb begin
        if (link.seen) begin
            readValue = st.outRev ? revUnits(link.crc, polyUnit(st.polySel))
                                  : link.crc;
            readValue = (readValue ^ st.xorMask) & widthMask(st.polySel);
        end else begin
            readValue = st.seed & widthMask(st.polySel);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register read decode
    always_comb begin
        mapped = 1'b1;
        readMux = 32'h00000000;
        case (paddr)
            OFF_DATA: readMux = readValue;
            OFF_CTRL: begin
                readMux[CTRL_RST_BIT] = st.modRst;
                readMux[CTRL_REVIN_LO +: 2] = st.inRev;
                readMux[CTRL_REVOUT_BIT] = st.outRev;
                readMux[CTRL_BUSY_BIT] = link.busy;
            end
            OFF_POLY: readMux[1:0] = st.polySel;
            OFF_SEED: readMux = st.seed;
            OFF_XOR: readMux = st.xorMask;
            OFF_STAT: readMux[1:0] = st.status;
            OFF_MASK: readMux[1:0] = st.mask;
            OFF_GATE: readMux[0] = st.gate;
            default: mapped = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // register updates
    always_comb begin
        logic [31:0] merged;
        logic [1:0] clrBits;
        logic [1:0] setBits;
        merged = 32'h00000000;
        clrBits = 2'h0;
        setBits = 2'h0;
        next_st = st;
        // zero wait: ready in the access cycle right after setup
        next_st.pready = setupPh;
        next_st.pslverr = setupPh && !mapped;
        if (setupPh && !pwrite) begin
            next_st.prdata = readMux;
        end
        // module reset pulse lasts exactly one clock
        next_st.modRst = 1'b0;
        if (accessPh && pwrite) begin
            merged = mergeLanes(readMux, pwdata, pstrb);
            case (paddr)
                OFF_CTRL: begin
                    if (pstrb[0]) begin
                        next_st.modRst = pwdata[CTRL_RST_BIT];
                        next_st.inRev = pwdata[CTRL_REVIN_LO +: 2];
                        next_st.outRev = pwdata[CTRL_REVOUT_BIT];
                    end
                end
                OFF_POLY: next_st.polySel = merged[1:0];
                OFF_SEED: next_st.seed = merged;
                OFF_XOR: next_st.xorMask = merged;
                // a disabled lane must not clear anything
                OFF_STAT: clrBits = pstrb[0] ? pwdata[1:0] : 2'h0;
                OFF_MASK: next_st.mask = merged[1:0];
                OFF_GATE: next_st.gate = merged[0];
                default: ;
            endcase
        end
        // sticky events, a new event beats a same-cycle clear
        setBits[ST_DONE] = calcDone;
        setBits[ST_DROP] = dropped;
        next_st.status = (st.status & ~clrBits) | setBits;
        next_st.busyPrev = link.busy;
        next_st.irq = |(next_st.status & next_st.mask);
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st <= '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h00000000,
                    polySel: POLY_RESET, seed: SEED_RESET,
                    xorMask: XOR_RESET, outRev: 1'b0, inRev: 2'h0,
                    modRst: 1'b0, status: 2'h0, mask: 2'h0, irq: 1'b0,
                    gate: 1'b0, busyPrev: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign crcIrq = st.irq;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    logic wrWord;
    logic wrHalf;
    logic wrByte;
    logic ctrlRstWr;
    assign wrWord = accepted && sizeUnit == UNIT_WORD;
    assign wrHalf = accepted && sizeUnit == UNIT_HALF;
    assign wrByte = accepted && sizeUnit == UNIT_BYTE;
    assign ctrlRstWr = accessPh && pwrite && paddr == OFF_CTRL
                       && pstrb[0] && pwdata[CTRL_RST_BIT];

    sequence s_wordRun;
        link.busy [*4] ##1 !link.busy;
    endsequence
    sequence s_halfRun;
        link.busy [*2] ##1 !link.busy;
    endsequence
    sequence s_rstPulse;
        st.modRst ##1 !st.modRst;
    endsequence

    property p_busySet;
        accepted |=> link.busy;
    endproperty
    a_busySet: assert property (p_busySet)
        else $error("busy flag not raised by data write");

    property p_wordLen;
        wrWord |=> s_wordRun;
    endproperty
    a_wordLen: assert property (p_wordLen)
        else $error("word calculation not four cycles");

    property p_halfLen;
        wrHalf |=> s_halfRun;
    endproperty
    a_halfLen: assert property (p_halfLen)
        else $error("halfword calculation not two cycles");

    property p_byteLen;
        wrByte |=> link.busy ##1 !link.busy;
    endproperty
    a_byteLen: assert property (p_byteLen)
        else $error("byte calculation not one cycle");

    property p_modRst;
        ctrlRstWr |=> s_rstPulse;
    endproperty
    a_modRst: assert property (p_modRst)
        else $error("module reset pulse not one cycle");

    property p_rstSeed;
        st.modRst |=> !link.busy && !link.seen
                      && readValue == (st.seed & widthMask(st.polySel));
    endproperty
    a_rstSeed: assert property (p_rstSeed)
        else $error("seed not returned after module reset");

    property p_ignore;
        dataWr && link.busy && !st.modRst |=> st.status[ST_DROP]
            && u_engine.st.left == $past(u_engine.st.left) - 3'h1;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("write during busy was accepted");

    property p_upper;
        st.polySel == SEL_CRC8 |-> readValue[31:8] == 24'h000000;
    endproperty
    a_upper: assert property (p_upper)
        else $error("upper result bits not zero for 8-bit crc");

endmodule // crcu_top

// file: verilog/crcu_pkg.sv
// shared constants, types and helper functions of the crc unit
package crcu_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_DATA = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_POLY = 8'h08;
    localparam logic [7:0] OFF_SEED = 8'h0c;
    localparam logic [7:0] OFF_XOR = 8'h10;
    localparam logic [7:0] OFF_STAT = 8'h14;
    localparam logic [7:0] OFF_MASK = 8'h18;
    localparam logic [7:0] OFF_GATE = 8'h1c;

    // values after reset
    localparam logic [31:0] SEED_RESET = 32'hffffffff;
    localparam logic [31:0] XOR_RESET = 32'h00000000;
    localparam logic [1:0] POLY_RESET = 2'h0;

    // control field positions
    localparam int CTRL_RST_BIT = 0;
    localparam int CTRL_REVIN_LO = 1;
    localparam int CTRL_REVOUT_BIT = 3;
    localparam int CTRL_BUSY_BIT = 4;

    // status and mask bits
    localparam int ST_DONE = 0;
    localparam int ST_DROP = 1;

    // polynomial choices and generators
    localparam logic [1:0] SEL_CRC32 = 2'h0;
    localparam logic [1:0] SEL_CRC16 = 2'h1;
    localparam logic [1:0] SEL_CRC8 = 2'h2;
    localparam logic [31:0] POLY32 = 32'h04c11db7;
    localparam logic [15:0] POLY16 = 16'h1021;
    localparam logic [7:0] POLY8 = 8'h07;

    // reversal units, also used as data size codes
    localparam logic [1:0] UNIT_NONE = 2'h0;
    localparam logic [1:0] UNIT_BYTE = 2'h1;
    localparam logic [1:0] UNIT_HALF = 2'h2;
    localparam logic [1:0] UNIT_WORD = 2'h3;

    // bytes per item, equal to the calculation cycles per item
    localparam logic [2:0] N_BYTE = 3'h1;
    localparam logic [2:0] N_HALF = 3'h2;
    localparam logic [2:0] N_WORD = 3'h4;

    // engine state
    typedef struct packed {
        logic [31:0] crcAl;
        logic [31:0] feed;
        logic [2:0] left;
        logic busy;
        logic seen;
    } crcu_eng_type;

    // register side state
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [1:0] polySel;
        logic [31:0] seed;
        logic [31:0] xorMask;
        logic outRev;
        logic [1:0] inRev;
        logic modRst;
        logic [1:0] status;
        logic [1:0] mask;
        logic irq;
        logic gate;
        logic busyPrev;
    } crcu_regs_type;

    // left shift that puts a narrow crc at the top of the word
    function automatic logic [4:0] alignShift(input logic [1:0] sel);
        case (sel)
            SEL_CRC16: alignShift = 5'h10;
            SEL_CRC8: alignShift = 5'h18;
            default: alignShift = 5'h00;
        endcase
    endfunction

    function automatic logic [31:0] widthMask(input logic [1:0] sel);
        widthMask = 32'hffffffff >> alignShift(sel);
    endfunction

    function automatic logic [31:0] polyAligned(input logic [1:0] sel);
        case (sel)
            SEL_CRC16: polyAligned = {POLY16, 16'h0000};
            SEL_CRC8: polyAligned = {POLY8, 24'h000000};
            default: polyAligned = POLY32;
        endcase
    endfunction

    function automatic logic [1:0] polyUnit(input logic [1:0] sel);
        case (sel)
            SEL_CRC16: polyUnit = UNIT_HALF;
            SEL_CRC8: polyUnit = UNIT_BYTE;
            default: polyUnit = UNIT_WORD;
        endcase
    endfunction

    // reverse bit order inside each byte, halfword or the whole word
    function automatic logic [31:0] revUnits(input logic [31:0] d,
                                             input logic [1:0] unit);
        int span;
        span = (unit == UNIT_BYTE) ? 8 : (unit == UNIT_HALF) ? 16 : 32;
        revUnits = d;
        if (unit != UNIT_NONE) begin
            for (int i = 0; i < 32; i++) begin
                revUnits[i] = d[(i / span) * span + span - 1 - (i % span)];
            end
        end
    endfunction

endpackage

// file: verilog/crcu_link_if.sv
// link between the register side and the crc engine
`timescale 1ns/100ps
interface crcu_link_if;
    logic start;
    logic [31:0] data;
    logic [2:0] nBytes;
    logic [1:0] polySel;
    logic [31:0] seed;
    logic reload;
    logic enable;
    logic busy;
    logic seen;
    logic [31:0] crc;

    modport engine (
        input start, data, nBytes, polySel, seed, reload, enable,
        output busy, seen, crc
    );
    modport regs (
        output start, data, nBytes, polySel, seed, reload, enable,
        input busy, seen, crc
    );
endinterface

// file: verilog/crcu_engine.sv
// byte-serial crc engine: one data byte folded in per clock
`timescale 1ns/100ps
module crcu_engine
    import crcu_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // register side
    crcu_link_if.engine link
);

    crcu_eng_type st;
    crcu_eng_type next_st;

    // crc kept left aligned so all widths share one shifter
    function automatic logic [31:0] stepByte(input logic [31:0] c,
                                             input logic [7:0] b,
                                             input logic [31:0] p);
        logic [31:0] r;
        r = c ^ {b, 24'h000000};
        for (int k = 0; k < 8; k++) begin
            r = r[31] ? ((r << 1) ^ p) : (r << 1);
        end
        stepByte = r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        if (link.reload) begin
            // engine reset reloads the seed and drops any calculation
            next_st.crcAl = link.seed << alignShift(link.polySel);
            next_st.busy = 1'b0;
            next_st.left = 3'h0;
            next_st.seen = 1'b0;
        end else if (link.enable && st.busy) begin
            next_st.crcAl = stepByte(st.crcAl, st.feed[31:24],
                                     polyAligned(link.polySel));
            next_st.feed = st.feed << 8;
            next_st.left = st.left - 3'h1;
            next_st.busy = (st.left != 3'h1);
        end else if (link.enable && link.start) begin
            // most significant byte of the item goes first
            next_st.feed = link.data << {4'h4 - {1'b0, link.nBytes}, 3'h0};
            next_st.left = link.nBytes;
            next_st.busy = 1'b1;
            next_st.seen = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st <= '{crcAl: SEED_RESET, feed: 32'h00000000, left: 3'h0,
                    busy: 1'b0, seen: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign link.busy = st.busy;
    assign link.seen = st.seen;
    assign link.crc = st.crcAl >> alignShift(link.polySel);

endmodule // crcu_engine

// file: test/test_crc_calculation_unit.sv
// self-checking bench of the crc unit, driven over apb
`timescale 1ns/100ps
module test_crc_calculation_unit
    import crcu_pkg::*;
;
    // clock, reset and apb master
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic crcIrq;
    logic [31:0] rdat;
    logic rerr;
    logic [31:0] mCrc;
    int badCount = 0;
    int nCompared = 0;

    always #10 clk_sys = ~clk_sys;

    crcu_top dut (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .paddr(paddr),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .crcIrq(crcIrq)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic stopTest();
        $display("compared %0d mismatches %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            badCount++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one idle cycle before each setup keeps every signal to one change
    task automatic apb(input logic [7:0] a, input logic wr,
                       input logic [31:0] wd, input logic [3:0] st);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        pstrb <= st;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        // values read here are those sampled at this rising edge
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            badCount++;
            stopTest();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] st);
        apb(a, 1'b1, d, st);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(a, 1'b0, 32'h00000000, 4'h0);
    endtask

    task automatic waitIdle(output int n);
        n = 0;
        do begin
            rd(OFF_CTRL);
            n++;
        end while (rdat[CTRL_BUSY_BIT] !== 1'b0 && n < 20);
    endtask

    // irq is registered from status and mask: let it settle first
    task automatic chkIrq(input logic exp);
        repeat (2) @(negedge clk_sys);
        chk("irq", {31'h0, crcIrq}, {31'h0, exp});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // reference model, msb first, narrow crc kept right aligned
    function automatic int polyW(input int p);
        return (p == 1) ? 16 : (p == 2) ? 8 : 32;
    endfunction

    function automatic logic [31:0] rv(input logic [31:0] d, input int span);
        logic [31:0] r;
        for (int i = 0; i < 32; i++) begin
            r[i] = d[(i / span) * span + span - 1 - (i % span)];
        end
        return r;
    endfunction

    function automatic logic [31:0] fold(input logic [31:0] c,
                                         input logic [7:0] b, input int p);
        int w;
        logic [31:0] g;
        w = polyW(p);
        g = (p == 1) ? {16'h0, POLY16} : (p == 2) ? {24'h0, POLY8} : POLY32;
        c = c ^ ({24'h0, b} << (w - 8));
        for (int i = 0; i < 8; i++) begin
            c = c[w - 1] ? ((c << 1) ^ g) : (c << 1);
        end
        return c & (32'hffffffff >> (32 - w));
    endfunction

    task automatic push(input logic [31:0] d, input int nb, input int ir,
                        input int p);
        int u;
        u = (nb == 1) ? 1 : (nb == 2) ? 2 : 3;
        u = (ir < u) ? ir : u;
        if (u > 0) begin
            d = rv(d, (u == 1) ? 8 : (u == 2) ? 16 : 32);
        end
        for (int k = nb - 1; k >= 0; k--) begin
            mCrc = fold(mCrc, d[8 * k +: 8], p);
        end
    endtask

    function automatic logic [31:0] res(input int p, input int orv,
                                        input logic [31:0] xv);
        logic [31:0] m;
        logic [31:0] r;
        m = 32'hffffffff >> (32 - polyW(p));
        r = mCrc & m;
        if (orv != 0) begin
            r = rv(r, polyW(p));
        end
        return (r ^ xv) & m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #(20 * 50000);
        badCount++;
        stopTest();
    end

    initial begin
        logic [31:0] items [3];
        logic [31:0] sv;
        logic [31:0] xv;
        int nbs [3];
        int n;
        int idx;
        items = '{32'h1d2c3b4a, 32'h0000e5f6, 32'h00000097};
        nbs = '{4, 2, 1};
        idx = 0;
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(OFF_POLY);
        chk("poly", rdat, 32'h00000000);
        rd(OFF_SEED);
        chk("seed", rdat, 32'hffffffff);
        rd(OFF_XOR);
        chk("xor", rdat, 32'h00000000);
        rd(OFF_CTRL);
        chk("ctrl", rdat, 32'h00000000);
        rd(OFF_DATA);
        chk("data seed", rdat, 32'hffffffff);
        rd(8'h20);
        chk("unmapped err", {31'h0, rerr}, 32'h00000001);
        chk("unmapped data", rdat, 32'h00000000);
        // gate still off: the write is dropped, flagged but masked
        wr(OFF_DATA, 32'h12345678, 4'hf);
        rd(OFF_DATA);
        chk("gated data", rdat, 32'hffffffff);
        rd(OFF_STAT);
        chk("drop flag", rdat, 32'h00000002);
        chkIrq(1'b0);
        wr(OFF_MASK, 32'h00000002, 4'hf);
        chkIrq(1'b1);
        wr(OFF_STAT, 32'h00000002, 4'hf);
        chkIrq(1'b0);
        wr(OFF_GATE, 32'h00000001, 4'hf);
        wr(OFF_MASK, 32'h00000003, 4'hf);
        // every polynomial code, input and output reversal, all sizes
        for (int p = 0; p < 4; p++) begin
            for (int ir = 0; ir < 4; ir++) begin
                for (int orv = 0; orv < 2; orv++) begin
                    sv = 32'hc3a59e10 + 32'(idx * 32'h01030507);
                    xv = 32'h0f0f00f0 ^ 32'(idx);
                    idx++;
                    wr(OFF_POLY, 32'(p), 4'hf);
                    wr(OFF_SEED, sv, 4'hf);
                    wr(OFF_XOR, xv, 4'hf);
                    wr(OFF_CTRL, 32'(orv * 8 + ir * 2 + 1), 4'hf);
                    rd(OFF_CTRL);
                    chk("ctrl", rdat, 32'(orv * 8 + ir * 2));
                    if (p == 0 || p == 3) begin
                        rd(OFF_DATA);
                        chk("seed back", rdat, sv);
                    end
                    mCrc = sv & (32'hffffffff >> (32 - polyW(p)));
                    for (int k = 0; k < 3; k++) begin
                        wr(OFF_DATA, items[k],
                           (nbs[k] == 4) ? 4'hf : (nbs[k] == 2) ? 4'h3 : 4'h1);
                        push(items[k], nbs[k], ir, p);
                        if (k == 0) begin
                            rd(OFF_CTRL);
                            chk("busy", {31'h0, rdat[CTRL_BUSY_BIT]},
                                32'h00000001);
                        end
                        waitIdle(n);
                        chk("busy time", 32'(n <= 3), 32'h00000001);
                        rd(OFF_DATA);
                        chk("crc", rdat, res(p, orv, xv));
                    end
                end
            end
        end
        // second write lands while busy and must be dropped
        wr(OFF_POLY, 32'h00000000, 4'hf);
        wr(OFF_SEED, 32'hffffffff, 4'hf);
        wr(OFF_XOR, 32'h00000000, 4'hf);
        wr(OFF_CTRL, 32'h00000001, 4'hf);
        wr(OFF_STAT, 32'h00000003, 4'hf);
        chkIrq(1'b0);
        mCrc = 32'hffffffff;
        wr(OFF_DATA, 32'ha1b2c3d4, 4'hf);
        wr(OFF_DATA, 32'h55aa55aa, 4'hf);
        push(32'ha1b2c3d4, 4, 0, 0);
        waitIdle(n);
        rd(OFF_DATA);
        chk("crc after drop", rdat, res(0, 0, 32'h0));
        rd(OFF_STAT);
        chk("status", rdat, 32'h00000003);
        chkIrq(1'b1);
        wr(OFF_STAT, 32'h00000003, 4'hf);
        chkIrq(1'b0);
        wr(OFF_CTRL, 32'h00000010, 4'hf);
        rd(OFF_CTRL);
        chk("busy write", rdat, 32'h00000000);
        stopTest();
    end

endmodule // test_crc_calculation_unit
